//--- hdl/fbx_pkg.sv
// Shared constants and types for the flag, branch, bit and load executor
package fbx_pkg;

  // ----------------------------------------------------------------
  // Register file and pointer pairs
  // ----------------------------------------------------------------
  localparam int          FBX_REG_COUNT = 32;
  localparam logic [4:0]  FBX_PTR_X     = 5'h1A;
  localparam logic [4:0]  FBX_PTR_Y     = 5'h1C;
  localparam logic [4:0]  FBX_PTR_Z     = 5'h1E;
  localparam logic [7:0]  FBX_RF_RESET  = 8'h00;
  localparam logic [15:0] FBX_STEP      = 16'h0001;

  // ----------------------------------------------------------------
  // Wishbone byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  FBX_ADR_INSTR    = 8'h00;
  localparam logic [7:0]  FBX_ADR_STATUS   = 8'h04;
  localparam logic [7:0]  FBX_ADR_PC       = 8'h08;
  localparam logic [7:0]  FBX_ADR_RF_INDEX = 8'h0C;
  localparam logic [7:0]  FBX_ADR_RF_DATA  = 8'h10;
  localparam logic [7:0]  FBX_ADR_CORE     = 8'h14;
  localparam logic [3:0]  FBX_SEL_ALL      = 4'hF;
  localparam logic [7:0]  FBX_FLAGS_RESET  = 8'h00;
  localparam logic [15:0] FBX_PC_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam int FBX_FLAG_C = 0;
  localparam int FBX_FLAG_Z = 1;
  localparam int FBX_FLAG_N = 2;
  localparam int FBX_FLAG_V = 3;
  localparam int FBX_FLAG_S = 4;
  localparam int FBX_FLAG_H = 5;
  localparam int FBX_FLAG_T = 6;
  localparam int FBX_FLAG_I = 7;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int FBX_OP_LSB    = 24;
  localparam int FBX_OP_W      = 6;
  localparam int FBX_DST_LSB   = 16;
  localparam int FBX_SRC_LSB   = 8;
  localparam int FBX_IDX_W     = 5;
  localparam int FBX_IMM_LSB   = 0;
  localparam int FBX_IMM_W     = 8;
  localparam int FBX_OP_GROUP  = 5;
  localparam int FBX_OP_RSV    = 4;
  localparam int FBX_OP_CLEAR  = 3;

  typedef enum logic [5:0] {
    OP_NOP                        = 6'h00,
    OP_BRANCH_TRANSFER_FLAG_CLEAR = 6'h01,
    OP_BRANCH_OVERFLOW_SET        = 6'h02,
    OP_BRANCH_OVERFLOW_CLEAR      = 6'h03,
    OP_BRANCH_IRQ_ENABLED         = 6'h04,
    OP_BRANCH_IRQ_DISABLED        = 6'h05,
    OP_IO_BIT_SET                 = 6'h06,
    OP_IO_BIT_CLEAR               = 6'h07,
    OP_SHIFT_LEFT                 = 6'h08,
    OP_SHIFT_RIGHT                = 6'h09,
    OP_ARITH_SHIFT_RIGHT          = 6'h0A,
    OP_ROTATE_RIGHT_VIA_CARRY     = 6'h0B,
    OP_NIBBLE_SWAP                = 6'h0C,
    OP_STATUS_BIT_SET_BY_INDEX    = 6'h0D,
    OP_STATUS_BIT_CLEAR_BY_INDEX  = 6'h0E,
    OP_FLAG_STORE_FROM_BIT        = 6'h0F,
    OP_FLAG_TO_REGISTER_BIT       = 6'h10,
    OP_REGISTER_COPY              = 6'h11,
    OP_REGISTER_PAIR_COPY         = 6'h12,
    OP_LOAD_CONSTANT              = 6'h13,
    OP_LOAD_VIA_POINTER           = 6'h14,
    OP_LOAD_VIA_POINTER_INC       = 6'h15,
    OP_LOAD_VIA_POINTER_DEC       = 6'h16,
    OP_LOAD_VIA_POINTER_OFFSET    = 6'h17,
    OP_ILLEGAL                    = 6'h3F
  } fbx_op_type;

  typedef struct packed {
    fbx_op_type op;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic       legal;
  } fbx_instr_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN1 = 2'b01,
    ST_RUN2 = 2'b10
  } fbx_state_type;

endpackage : fbx_pkg

//--- hdl/fbx_decode.sv
// Instruction word decoder for the executor
`timescale 1ns/1ps
module fbx_decode
  import fbx_pkg::*;
(
  input  logic [31:0]   instr_word,
  output fbx_instr_type instr
);

  logic [5:0] raw_op;

  assign raw_op = instr_word[FBX_OP_LSB +: FBX_OP_W];

  always_comb
  begin
    instr.dst   = instr_word[FBX_DST_LSB +: FBX_IDX_W];
    instr.src   = instr_word[FBX_SRC_LSB +: FBX_IDX_W];
    instr.imm   = instr_word[FBX_IMM_LSB +: FBX_IMM_W];
    instr.legal = 1'b1;
    instr.op    = OP_ILLEGAL;
    if (raw_op[FBX_OP_GROUP])
    begin
      // Dedicated flag set/clear: flag number sits in the opcode
      if (raw_op[FBX_OP_RSV])
        instr.legal = 1'b0;
      else if (raw_op[FBX_OP_CLEAR])
        instr.op = OP_STATUS_BIT_CLEAR_BY_INDEX;
      else
        instr.op = OP_STATUS_BIT_SET_BY_INDEX;
      instr.imm = {5'h00, raw_op[2:0]};
    end
    else if (raw_op <= OP_LOAD_VIA_POINTER_OFFSET)
      instr.op = fbx_op_type'(raw_op);
    else
      instr.legal = 1'b0;
  end

endmodule : fbx_decode

//--- hdl/fbx_shift.sv
// Shift, rotate and nibble swap unit with flag results
`timescale 1ns/1ps
module fbx_shift
  import fbx_pkg::*;
(
  input  fbx_op_type op,
  input  logic [7:0] value,
  input  logic [7:0] flags_in,
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  logic carry;

  always_comb
  begin
    carry = value[0];
    case (op)
      OP_SHIFT_LEFT:
      begin
        result = {value[6:0], 1'b0};
        carry  = value[7];
      end
      OP_SHIFT_RIGHT:            result = {1'b0, value[7:1]};
      OP_ARITH_SHIFT_RIGHT:      result = {value[7], value[7:1]};
      OP_ROTATE_RIGHT_VIA_CARRY: result = {flags_in[FBX_FLAG_C], value[7:1]};
      default:                   result = {value[3:0], value[7:4]};
    endcase
    flags_out = flags_in;
    // Swap leaves every flag alone
    if (op != OP_NIBBLE_SWAP)
    begin
      flags_out[FBX_FLAG_C] = carry;
      flags_out[FBX_FLAG_Z] = (result == FBX_RF_RESET);
      flags_out[FBX_FLAG_N] = result[7];
      flags_out[FBX_FLAG_V] = result[7] ^ carry;
    end
  end

endmodule : fbx_shift

//--- hdl/fbx_exec.sv
// Executor for flag branches, I/O bit ops, shifts, flag ops, moves and loads
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module fbx_exec
  import fbx_pkg::*;
(
  input  logic        clock,
  input  logic        reset,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  output logic [15:0] dmem_addr,
  output logic        dmem_rd_en,
  input  logic [7:0]  dmem_rdata,
  output logic [4:0]  io_addr,
  output logic        io_rd_en,
  output logic        io_wr_en,
  output logic [7:0]  io_wdata,
  input  logic [7:0]  io_rdata,
  output logic        busy
);

  // ----------------------------------------------------------------
  // State and datapath
  // ----------------------------------------------------------------
  fbx_state_type state;
  fbx_state_type next_state;
  fbx_instr_type ins;
  logic [31:0]   instr_word;
  logic [31:0]   next_instr_word;
  logic [7:0]    flags;
  logic [7:0]    next_flags;
  logic [15:0]   pc;
  logic [15:0]   next_pc;
  logic [4:0]    rf_index;
  logic [4:0]    next_rf_index;
  logic          illegal;
  logic          next_illegal;
  logic [15:0]   next_dmem_addr;
  logic          next_dmem_rd_en;
  logic [4:0]    next_io_addr;
  logic          next_io_rd_en;
  logic          next_io_wr_en;
  logic [7:0]    next_io_wdata;
  logic          next_ack;
  logic [31:0]   next_dat;
  logic [7:0]    rf [FBX_REG_COUNT];
  logic          we_a;
  logic          we_b;
  logic [4:0]    idx_a;
  logic [4:0]    idx_b;
  logic [7:0]    dat_a;
  logic [7:0]    dat_b;
  logic [7:0]    rd_val;
  logic [7:0]    rr_val;
  logic          rr_bit;
  logic [7:0]    sh_result;
  logic [7:0]    sh_flags;
  logic [7:0]    bit_mask;
  logic [4:0]    ptr_idx;
  logic [15:0]   ptr_val;
  logic [15:0]   ptr_inc;
  logic [15:0]   ptr_dec;
  logic [15:0]   disp_addr;
  logic [15:0]   pc_plus1;
  logic [15:0]   branch_target;
  logic          branch_take;
  logic          wb_write;

  fbx_decode u_decode (
    .instr_word (instr_word),
    .instr      (ins)
  );

  fbx_shift u_shift (
    .op        (ins.op),
    .value     (rd_val),
    .flags_in  (flags),
    .result    (sh_result),
    .flags_out (sh_flags)
  );

  assign rd_val    = rf[ins.dst];
  assign rr_val    = rf[ins.src];
  assign rr_bit    = rr_val[ins.imm[2:0]];
  assign bit_mask  = 8'h01 << ins.imm[2:0];
  assign ptr_idx   = (ins.imm[1:0] == 2'b00) ? FBX_PTR_X :
                     (ins.imm[1:0] == 2'b01) ? FBX_PTR_Y : FBX_PTR_Z;
  assign ptr_val   = {rf[{ptr_idx[4:1], 1'b1}], rf[ptr_idx]};
  assign ptr_inc   = ptr_val + FBX_STEP;
  assign ptr_dec   = ptr_val - FBX_STEP;
  assign disp_addr = {rf[{FBX_PTR_Y[4:1], 1'b1}], rf[FBX_PTR_Y]}
                     + {10'h000, ins.imm[5:0]};
  assign pc_plus1  = pc + FBX_STEP;
  assign branch_target = pc + {{8{ins.imm[7]}}, ins.imm} + FBX_STEP;
  assign busy      = (state != ST_IDLE);
  assign wb_write  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && !busy;

  always_comb
  begin
    case (ins.op)
      OP_BRANCH_TRANSFER_FLAG_CLEAR: branch_take = !flags[FBX_FLAG_T];
      OP_BRANCH_OVERFLOW_SET:        branch_take = flags[FBX_FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR:      branch_take = !flags[FBX_FLAG_V];
      OP_BRANCH_IRQ_ENABLED:         branch_take = flags[FBX_FLAG_I];
      OP_BRANCH_IRQ_DISABLED:        branch_take = !flags[FBX_FLAG_I];
      default:                       branch_take = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and bus writes
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_instr_word = instr_word;
    next_flags      = flags;
    next_pc         = pc;
    next_rf_index   = rf_index;
    next_illegal    = illegal;
    next_dmem_addr  = dmem_addr;
    next_dmem_rd_en = 1'b0;
    next_io_addr    = io_addr;
    next_io_rd_en   = 1'b0;
    next_io_wr_en   = 1'b0;
    next_io_wdata   = io_wdata;
    we_a  = 1'b0;
    we_b  = 1'b0;
    idx_a = ins.dst;
    idx_b = {ins.dst[4:1], 1'b1};
    dat_a = sh_result;
    dat_b = rf[{ins.src[4:1], 1'b1}];
    unique case (state)
      ST_IDLE:
      begin
        if (wb_write)
        begin
          case (wb_adr_i)
            FBX_ADR_INSTR:
              if (wb_sel_i == FBX_SEL_ALL)
              begin
                next_instr_word = wb_dat_i;
                next_state      = ST_RUN1;
              end
            FBX_ADR_STATUS:
              if (wb_sel_i[0])
                next_flags = wb_dat_i[7:0];
            FBX_ADR_PC:
            begin
              if (wb_sel_i[0])
                next_pc[7:0] = wb_dat_i[7:0];
              if (wb_sel_i[1])
                next_pc[15:8] = wb_dat_i[15:8];
            end
            FBX_ADR_RF_INDEX:
              if (wb_sel_i[0])
                next_rf_index = wb_dat_i[4:0];
            FBX_ADR_RF_DATA:
            begin
              we_a  = wb_sel_i[0];
              idx_a = rf_index;
              dat_a = wb_dat_i[7:0];
            end
            default:
              next_flags = flags;
          endcase
        end
      end
      ST_RUN1:
      begin
        next_state   = ST_IDLE;
        next_illegal = !ins.legal;
        next_pc      = branch_take ? pc : pc_plus1;
        case (ins.op)
          OP_BRANCH_TRANSFER_FLAG_CLEAR, OP_BRANCH_OVERFLOW_SET,
          OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED,
          OP_BRANCH_IRQ_DISABLED:
            if (branch_take)
              next_state = ST_RUN2;
          OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
          begin
            next_io_addr  = ins.src;
            next_io_rd_en = 1'b1;
            next_state    = ST_RUN2;
          end
          OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ARITH_SHIFT_RIGHT,
          OP_ROTATE_RIGHT_VIA_CARRY, OP_NIBBLE_SWAP:
          begin
            we_a       = 1'b1;
            next_flags = sh_flags;
          end
          OP_STATUS_BIT_SET_BY_INDEX:
            next_flags = flags | bit_mask;
          OP_STATUS_BIT_CLEAR_BY_INDEX:
            next_flags = flags & ~bit_mask;
          OP_FLAG_STORE_FROM_BIT:
            next_flags[FBX_FLAG_T] = rr_bit;
          OP_FLAG_TO_REGISTER_BIT:
          begin
            we_a  = 1'b1;
            dat_a = flags[FBX_FLAG_T] ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
          end
          OP_REGISTER_COPY:
          begin
            we_a  = 1'b1;
            dat_a = rr_val;
          end
          OP_REGISTER_PAIR_COPY:
          begin
            we_a  = 1'b1;
            we_b  = 1'b1;
            idx_a = {ins.dst[4:1], 1'b0};
            dat_a = rf[{ins.src[4:1], 1'b0}];
          end
          OP_LOAD_CONSTANT:
          begin
            we_a  = 1'b1;
            dat_a = ins.imm;
          end
          OP_LOAD_VIA_POINTER, OP_LOAD_VIA_POINTER_INC:
          begin
            next_dmem_addr  = ptr_val;
            next_dmem_rd_en = 1'b1;
            next_state      = ST_RUN2;
            we_a  = (ins.op == OP_LOAD_VIA_POINTER_INC);
            we_b  = we_a;
            idx_a = ptr_idx;
            idx_b = {ptr_idx[4:1], 1'b1};
            dat_a = ptr_inc[7:0];
            dat_b = ptr_inc[15:8];
          end
          OP_LOAD_VIA_POINTER_DEC:
          begin
            next_dmem_addr  = ptr_dec;
            next_dmem_rd_en = 1'b1;
            next_state      = ST_RUN2;
            we_a  = 1'b1;
            we_b  = 1'b1;
            idx_a = ptr_idx;
            idx_b = {ptr_idx[4:1], 1'b1};
            dat_a = ptr_dec[7:0];
            dat_b = ptr_dec[15:8];
          end
          OP_LOAD_VIA_POINTER_OFFSET:
          begin
            next_dmem_addr  = disp_addr;
            next_dmem_rd_en = 1'b1;
            next_state      = ST_RUN2;
          end
          default:
            next_flags = flags;
        endcase
      end
      ST_RUN2:
      begin
        next_state = ST_IDLE;
        if (branch_take)
          next_pc = branch_target;
        if (ins.op == OP_IO_BIT_SET)
          next_io_wdata = io_rdata | bit_mask;
        else
          next_io_wdata = io_rdata & ~bit_mask;
        next_io_wr_en = (ins.op == OP_IO_BIT_SET) || (ins.op == OP_IO_BIT_CLEAR);
        we_a  = dmem_rd_en;
        dat_a = dmem_rdata;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Wishbone answer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    case (wb_adr_i)
      FBX_ADR_INSTR:    next_dat = instr_word;
      FBX_ADR_STATUS:   next_dat = {24'h00_0000, flags};
      FBX_ADR_PC:       next_dat = {16'h0000, pc};
      FBX_ADR_RF_INDEX: next_dat = {27'h000_0000, rf_index};
      FBX_ADR_RF_DATA:  next_dat = {24'h00_0000, rf[rf_index]};
      FBX_ADR_CORE:     next_dat = {30'h0000_0000, illegal, busy};
      default:          next_dat = '0;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state      <= ST_IDLE;
      instr_word <= '0;
      flags      <= FBX_FLAGS_RESET;
      pc         <= FBX_PC_RESET;
      rf_index   <= '0;
      illegal    <= 1'b0;
      dmem_addr  <= '0;
      dmem_rd_en <= 1'b0;
      io_addr    <= '0;
      io_rd_en   <= 1'b0;
      io_wr_en   <= 1'b0;
      io_wdata   <= '0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= '0;
    end
    else
    begin
      state      <= next_state;
      instr_word <= next_instr_word;
      flags      <= next_flags;
      pc         <= next_pc;
      rf_index   <= next_rf_index;
      illegal    <= next_illegal;
      dmem_addr  <= next_dmem_addr;
      dmem_rd_en <= next_dmem_rd_en;
      io_addr    <= next_io_addr;
      io_rd_en   <= next_io_rd_en;
      io_wr_en   <= next_io_wr_en;
      io_wdata   <= next_io_wdata;
      wb_ack_o   <= next_ack;
      wb_dat_o   <= next_dat;
    end
  end

  genvar g;
  generate
    for (g = 0; g < FBX_REG_COUNT; g++)
    begin : g_rf
      always_ff @(posedge clock or posedge reset)
      begin
        if (reset)
          rf[g] <= FBX_RF_RESET;
        else if (we_a && (idx_a == 5'(g)))
          rf[g] <= dat_a;
        else if (we_b && (idx_b == 5'(g)))
          rf[g] <= dat_b;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_run1(fbx_op_type code);
    (state == ST_RUN1) && (ins.op == code);
  endsequence
  sequence s_io_access;
    (io_rd_en && state == ST_RUN2) ##1 io_wr_en;
  endsequence

  property p_tclr_taken;
    s_run1(OP_BRANCH_TRANSFER_FLAG_CLEAR) ##0 !flags[FBX_FLAG_T] |=>
      (state == ST_RUN2 && flags == $past(flags)) ##1 (pc == $past(branch_target));
  endproperty
  a_tclr_taken: assert property (p_tclr_taken) else $error("transfer branch wrong");
  property p_ovf_set;
    s_run1(OP_BRANCH_OVERFLOW_SET) |=> ((state == ST_RUN2) == $past(flags[FBX_FLAG_V]));
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow branch wrong");
  property p_ovf_clear_skip;
    s_run1(OP_BRANCH_OVERFLOW_CLEAR) ##0 flags[FBX_FLAG_V] |=>
      (state == ST_IDLE && pc == $past(pc_plus1));
  endproperty
  a_ovf_clear_skip: assert property (p_ovf_clear_skip) else $error("untaken branch wrong");
  property p_irq_off;
    s_run1(OP_BRANCH_IRQ_DISABLED) |=> ((state == ST_RUN2) != $past(flags[FBX_FLAG_I]));
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt branch wrong");
  property p_io_set;
    s_run1(OP_IO_BIT_SET) |=> s_io_access ##0 ((io_wdata & bit_mask) != '0);
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_io_clear;
    s_run1(OP_IO_BIT_CLEAR) |=> s_io_access ##0 ((io_wdata & bit_mask) == '0);
  endproperty
  a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");
  property p_shift_left;
    s_run1(OP_SHIFT_LEFT) |-> we_a && dat_a == {rd_val[6:0], 1'b0}
      && next_flags[FBX_FLAG_C] == rd_val[7];
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("shift left wrong");
  property p_swap;
    s_run1(OP_NIBBLE_SWAP) |-> (we_a && dat_a == {rd_val[3:0], rd_val[7:4]})
      ##1 (flags == $past(flags));
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_flag_store;
    s_run1(OP_FLAG_STORE_FROM_BIT) |=> (flags[FBX_FLAG_T] == $past(rr_bit));
  endproperty
  a_flag_store: assert property (p_flag_store) else $error("bit store wrong");
  property p_index_set;
    s_run1(OP_STATUS_BIT_SET_BY_INDEX) |=> (flags == ($past(flags) | $past(bit_mask)));
  endproperty
  a_index_set: assert property (p_index_set) else $error("flag set wrong");
  property p_post_inc;
    s_run1(OP_LOAD_VIA_POINTER_INC) |=> (dmem_rd_en && dmem_addr == $past(ptr_val)
      && ptr_val == $past(ptr_inc)) ##1 (state == ST_IDLE);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");
  property p_pre_dec;
    s_run1(OP_LOAD_VIA_POINTER_DEC) |=> dmem_rd_en && dmem_addr == $past(ptr_dec)
      && ptr_val == $past(ptr_dec);
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre decrement wrong");
  property p_disp;
    s_run1(OP_LOAD_VIA_POINTER_OFFSET) |=> (dmem_rd_en && dmem_addr == $past(disp_addr)
      && flags == $past(flags)) ##1 (state == ST_IDLE);
  endproperty
  a_disp: assert property (p_disp) else $error("displacement load wrong");
  property p_copy;
    s_run1(OP_REGISTER_COPY) |-> (we_a && dat_a == rr_val && next_state == ST_IDLE
      && next_flags == flags);
  endproperty
  a_copy: assert property (p_copy) else $error("register copy wrong");

endmodule : fbx_exec

//--- bench/tb_top.sv
// Self-checking bench for the flag, branch, bit and load executor
`timescale 1ns/1ps
module tb_top;
  import fbx_pkg::*;
  logic        clock = 0;
  logic        reset = 1;
  logic        wb_cyc_i = 0;
  logic        wb_stb_i = 0;
  logic        wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = FBX_SEL_ALL;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, dmem_rd_en, io_rd_en, io_wr_en, busy;
  logic [15:0] dmem_addr;
  logic [7:0]  dmem_rdata, io_wdata, io_rdata, fl;
  logic [4:0]  io_addr;
  logic [12:0] io_last;
  logic [39:0] st [8];
  int          err_count = 0, n_compared = 0, cyc_n = 0, nb = 0, tk;

  fbx_exec dut_u (.clock, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .dmem_addr, .dmem_rd_en, .dmem_rdata, .io_addr,
    .io_rd_en, .io_wr_en, .io_wdata, .io_rdata, .busy);

  // Memory answers only while its read strobe is up, so a missing strobe shows
  assign dmem_rdata = dmem_rd_en ? (dmem_addr[7:0] ^ dmem_addr[15:8] ^ 8'h3C) : 8'h00;
  assign io_rdata   = io_rd_en ? 8'h5A : 8'h00;
  always #2.5 clock = ~clock;

  always @(posedge clock)
  begin
    cyc_n <= cyc_n + 1;
    if (busy) nb <= nb + 1;
    if (io_wr_en) io_last <= {io_addr, io_wdata};
    if (cyc_n == 20000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= w;
    wb_sel_i <= FBX_SEL_ALL;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clock);
  endtask : wb

  // Launches one instruction, waits for idle and checks its busy cycles
  task automatic ex(input logic [7:0] op, input logic [4:0] d, input logic [4:0] s,
                    input logic [7:0] im, input int n);
    nb = 0;
    wb(1'b1, FBX_ADR_INSTR, {2'b00, op[5:0], 3'b000, d, 3'b000, s, im});
    do wb(1'b0, FBX_ADR_CORE, 0); while (rd[0] !== 1'b0);
    chk(nb, n);
  endtask : ex

  task automatic ld(input logic [4:0] r, input logic [7:0] v);
    ex(8'h13, r, 5'd0, v, 1);
  endtask : ld

  task automatic rr(input logic [4:0] r, input logic [7:0] e);
    wb(1'b1, FBX_ADR_RF_INDEX, {27'd0, r});
    wb(1'b0, FBX_ADR_RF_DATA, 0);
    chk(rd, {24'd0, e});
  endtask : rr

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial
  begin
    // Entries: op, start value, start flags, result, flags after
    st = '{40'h08_8100_0209, 40'h08_4000_800C, 40'h09_8100_4009, 40'h09_0100_000B,
           40'h0A_8100_C005, 40'h0B_8101_C005, 40'h0B_8100_4009, 40'h0C_81FF_18FF};
    repeat (5) @(posedge clock);
    reset <= 0;
    @(posedge clock);
    wb(1'b0, FBX_ADR_STATUS, 0);
    chk(rd, 0);
    foreach (st[i])
    begin
      ld(5'd16, st[i][31:24]);
      wb(1'b1, FBX_ADR_STATUS, st[i][23:16]);
      ex(st[i][39:32], 5'd16, 5'd16, 8'h00, 1);
      rr(5'd16, st[i][15:8]);
      wb(1'b0, FBX_ADR_STATUS, 0);
      chk(rd, st[i][7:0]);
    end
    $display("shift test done");
    for (int k = 0; k < 32; k++)
    begin
      fl = 8'h01 << k[2:0];
      wb(1'b1, FBX_ADR_STATUS, k[3] ? 8'hFF : 8'h00);
      ex(k[4] ? 8'h20 + k[3:0] : 8'h0D + k[3], 0, 0, k[2:0], 1);
      wb(1'b0, FBX_ADR_STATUS, 0);
      chk(rd, {24'd0, k[3] ? ~fl : fl});
    end
    $display("flag test done");
    wb(1'b1, FBX_ADR_STATUS, 0);
    ld(5'd16, 8'h04);
    ld(5'd17, 8'h00);
    ex(8'h0F, 0, 5'd16, 8'h02, 1);
    ex(8'h10, 5'd17, 0, 8'h07, 1);
    rr(5'd17, 8'h80);
    wb(1'b0, FBX_ADR_STATUS, 0);
    chk(rd, 8'h40);
    $display("bit transfer test done");
    for (int i = 0; i < 10; i++)
    begin
      tk = i % 2;
      fl = (i < 2) ? 8'h40 : (i < 6) ? 8'h08 : 8'h80;
      fl = ((i / 2 == 1 || i / 2 == 3) ? tk : !tk) ? fl : 8'h00;
      wb(1'b1, FBX_ADR_PC, 16'h0010);
      wb(1'b1, FBX_ADR_STATUS, fl);
      ex(8'h01 + i / 2, 0, 0, 8'hFE, tk + 1);
      wb(1'b0, FBX_ADR_PC, 0);
      chk(rd, tk ? 16'h000F : 16'h0011);
      wb(1'b0, FBX_ADR_STATUS, 0);
      chk(rd, fl);
    end
    $display("branch test done");
    ex(8'h06, 0, 5'd3, 8'h00, 2);
    chk(io_last, {5'd3, 8'h5B});
    ex(8'h07, 0, 5'd3, 8'h01, 2);
    chk(io_last, {5'd3, 8'h58});
    $display("io bit test done");
    ld(5'd26, 8'h20);
    ld(5'd27, 8'h01);
    ld(5'd28, 8'h00);
    ld(5'd29, 8'h02);
    ex(8'h14, 5'd5, 0, 8'h00, 2);
    rr(5'd5, 8'h1D);
    ex(8'h15, 5'd6, 0, 8'h00, 2);
    rr(5'd26, 8'h21);
    ex(8'h16, 5'd7, 0, 8'h01, 2);
    rr(5'd7, 8'hC2);
    rr(5'd28, 8'hFF);
    ex(8'h17, 5'd8, 0, 8'h21, 2);
    rr(5'd8, 8'h1E);
    rr(5'd28, 8'hFF);
    ex(8'h12, 5'd2, 5'd26, 8'h00, 1);
    rr(5'd3, 8'h01);
    ex(8'h11, 5'd9, 5'd28, 8'h00, 1);
    rr(5'd9, 8'hFF);
    wb(1'b1, FBX_ADR_RF_INDEX, 32'd10);
    wb(1'b1, FBX_ADR_RF_DATA, 32'h0000_00A5);
    rr(5'd10, 8'hA5);
    ex(8'h3F, 0, 0, 8'h00, 1);
    chk(rd, 32'h0000_0002);
    wb(1'b0, 8'h18, 0);
    chk(rd, 0);
    $display("load and move test done");
    close_out();
  end
endmodule : tb_top
